/* File: core/rspc_pkg.sv */
package rspc_pkg;
  // =====================================================
  // clocks and timing
  // =====================================================
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int SLOW_CLK_HZ = 32_000;
  localparam int RESET_TIME_MS = 2;
  localparam int FW_LOAD_DELAY_MS = 20;
  localparam int RESET_CYC = RESET_TIME_MS * (REF_CLK_HZ / 1000);
  localparam int FW_LOAD_DELAY_CYC = FW_LOAD_DELAY_MS * (REF_CLK_HZ / 1000);
  localparam int SLOW_HALF_CYC = REF_CLK_HZ / (2 * SLOW_CLK_HZ);
  localparam int LISTEN_TICKS = 3200;
  localparam int WINDOW_TICKS = 32;
  localparam int NUM_IO = 4;
  localparam int CAL_W = 16;
  localparam int RTC_W = 32;
  // =====================================================
  // reset values
  // =====================================================
  localparam logic SUPPLY_EN_RST = 1'b1;
  localparam logic SUPPLY_OE_RST = 1'b1;
  // =====================================================
  // state machines
  // =====================================================
  typedef enum logic [2:0] {
    DST_BOOT = 3'b000,
    DST_RUN = 3'b001,
    DST_SLEEP = 3'b010,
    DST_LISTEN = 3'b011,
    DST_SHDN = 3'b100
  } rspc_dev_state_t;
  typedef enum logic [1:0] {
    HST_SHDN = 2'b00,
    HST_WAIT = 2'b01,
    HST_LOAD = 2'b10,
    HST_RUN = 2'b11
  } rspc_host_state_t;
endpackage

/* File: core/rspc_if.sv */
`timescale 1ns/1ps
interface rspc_if #(parameter int NIO = 4);
  // host drives reset only low (open drain) and shutdown, slow clock, test select
  logic reset_out;
  logic reset_oe;
  logic shutdown_n;
  logic slow_clk;
  logic test_out;
  logic test_oe;
  logic fw_start;
  logic supply_en_out;
  logic supply_en_oe;
  logic [NIO-1:0] io_out;
  logic [NIO-1:0] io_oe;
  logic reset_n;
  logic test_en;
  logic supply_en;
  // =====================================================
  // pin resolution: pull-up, pull-downs
  // =====================================================
  assign reset_n = reset_oe ? reset_out : 1'b1;
  assign test_en = test_oe ? test_out : 1'b0;
  assign supply_en = supply_en_oe ? supply_en_out : 1'b0;
  modport dev (
    input reset_n, shutdown_n, slow_clk, test_en, fw_start,
    output supply_en_out, supply_en_oe, io_out, io_oe
  );
  modport host (
    output reset_out, reset_oe, shutdown_n, slow_clk, test_out, test_oe, fw_start,
    input supply_en, io_out, io_oe
  );
endinterface

/* File: core/rspc_dev.sv */
`timescale 1ns/1ps
module rspc_dev
  import rspc_pkg::*;
#(
  parameter int NIO = NUM_IO,
  parameter int LISTEN_TICKS_P = LISTEN_TICKS,
  parameter int WINDOW_TICKS_P = WINDOW_TICKS
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  rspc_if.dev LINK,
  input wire logic PS_EN_I,
  input wire logic [NIO-1:0] IO_OUT_I,
  input wire logic [NIO-1:0] IO_OE_I,
  input wire logic [NIO-1:0] FW_DFLT_OUT_I,
  input wire logic [NIO-1:0] FW_DFLT_OE_I,
  output logic SYS_RESET_N_O,
  output logic CORE_SUPPLY_ON_O,
  output logic RADIO_ON_O,
  output logic RAM_RETAIN_O,
  output logic TEST_MODE_O,
  output logic [2:0] STATE_O,
  output logic [RTC_W-1:0] RTC_O,
  output logic [CAL_W-1:0] CAL_PERIOD_O
);
  // =====================================================
  // parameter checks
  // =====================================================
  if (NIO < 1) begin : g_chk_nio
    $error("NIO must be at least 1");
  end
  if (LISTEN_TICKS_P < 2 || LISTEN_TICKS_P > 65535) begin : g_chk_listen
    $error("LISTEN_TICKS_P out of range");
  end
  if (WINDOW_TICKS_P < 1 || WINDOW_TICKS_P >= LISTEN_TICKS_P) begin : g_chk_win
    $error("WINDOW_TICKS_P out of range");
  end
  localparam logic [15:0] LISTEN_LAST = 16'(LISTEN_TICKS_P - 1);
  localparam logic [15:0] WINDOW_LAST = 16'(WINDOW_TICKS_P - 1);
  // =====================================================
  // reset: power-on or pin, async assert, sync release
  // =====================================================
  logic arst_n;
  logic [1:0] rst_sync_q;
  logic sys_rst_n;
  assign arst_n = RESET_N_I & LINK.reset_n;
  always_ff @(posedge REF_CLK_I or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign sys_rst_n = rst_sync_q[1];
  assign SYS_RESET_N_O = sys_rst_n;
  // =====================================================
  // pin synchronisers
  // =====================================================
  logic shdn_meta_q;
  logic shdn_n_q;
  logic slow_meta_q;
  logic slow_sync_q;
  logic slow_prev_q;
  logic test_meta_q;
  logic test_q;
  logic slow_tick;
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      shdn_meta_q <= 1'b0;
      shdn_n_q <= 1'b0;
    end else begin
      shdn_meta_q <= LINK.shutdown_n;
      shdn_n_q <= shdn_meta_q;
    end
  end
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      slow_meta_q <= 1'b0;
      slow_sync_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_meta_q <= LINK.slow_clk;
      slow_sync_q <= slow_meta_q;
      slow_prev_q <= slow_sync_q;
    end
  end
  assign slow_tick = slow_sync_q & ~slow_prev_q;
  // undriven test select reads low, so normal mode
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      test_meta_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      test_meta_q <= LINK.test_en;
      test_q <= test_meta_q;
    end
  end
  assign TEST_MODE_O = test_q;
  // =====================================================
  // slow clock real time and calibration
  // =====================================================
  logic [RTC_W-1:0] rtc_q;
  logic [CAL_W-1:0] cal_cnt_q;
  logic [CAL_W-1:0] cal_period_q;
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      rtc_q <= '0;
    end else if (slow_tick) begin
      rtc_q <= rtc_q + RTC_W'(1);
    end
  end
  // fast cycles per slow period; the count saturates, but the period output only updates on a slow tick
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      cal_cnt_q <= '0;
      cal_period_q <= '0;
    end else if (slow_tick) begin
      cal_cnt_q <= '0;
      cal_period_q <= cal_cnt_q + CAL_W'(1);
    end else if (cal_cnt_q != '1) begin
      cal_cnt_q <= cal_cnt_q + CAL_W'(1);
    end
  end
  assign RTC_O = rtc_q;
  assign CAL_PERIOD_O = cal_period_q;
  // =====================================================
  // power state machine
  // =====================================================
  rspc_dev_state_t state_q;
  rspc_dev_state_t state_d;
  logic fw_shdn_q;
  logic [15:0] tick_cnt_q;
  logic tick_last;
  always_comb begin
    tick_last = 1'b0;
    if (state_q == DST_SLEEP) begin
      tick_last = (tick_cnt_q == LISTEN_LAST);
    end else if (state_q == DST_LISTEN) begin
      tick_last = (tick_cnt_q == WINDOW_LAST);
    end
  end
  always_comb begin
    state_d = state_q;
    if (!shdn_n_q) begin
      state_d = DST_SHDN;
    end else begin
      case (state_q)
        DST_SHDN: begin
          state_d = DST_BOOT;
        end
        DST_BOOT: begin
          if (LINK.fw_start) begin
            state_d = DST_RUN;
          end
        end
        DST_RUN: begin
          if (PS_EN_I) begin
            state_d = DST_SLEEP;
          end
        end
        DST_SLEEP: begin
          if (!PS_EN_I) begin
            state_d = DST_RUN;
          end else if (slow_tick && tick_last) begin
            state_d = DST_LISTEN;
          end
        end
        DST_LISTEN: begin
          if (!PS_EN_I) begin
            state_d = DST_RUN;
          end else if (slow_tick && tick_last) begin
            state_d = DST_SLEEP;
          end
        end
        default: begin
          state_d = DST_BOOT;
        end
      endcase
    end
  end
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      state_q <= DST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end
  // slow ticks counted inside each sleep or listen phase
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      tick_cnt_q <= '0;
    end else if (state_d != state_q) begin
      tick_cnt_q <= '0;
    end else if (slow_tick) begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end
  // remembers whether firmware was running when shutdown came
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      fw_shdn_q <= 1'b0;
    end else if (state_d == DST_SHDN && state_q != DST_SHDN) begin
      fw_shdn_q <= (state_q != DST_BOOT);
    end
  end
  // =====================================================
  // pin and power outputs
  // =====================================================
  logic sup_out_q;
  logic sup_oe_q;
  logic [NIO-1:0] io_out_q;
  logic [NIO-1:0] io_oe_q;
  logic core_on_q;
  logic radio_on_q;
  logic ram_keep_q;
  logic fw_shdn_d;
  assign fw_shdn_d = (state_d == DST_SHDN && state_q != DST_SHDN) ?
                     (state_q != DST_BOOT) : fw_shdn_q;
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sup_out_q <= SUPPLY_EN_RST;
      sup_oe_q <= SUPPLY_OE_RST;
    end else if (state_d == DST_BOOT) begin
      sup_out_q <= 1'b1;
      sup_oe_q <= 1'b1;
    end else if (state_d == DST_SHDN) begin
      // if firmware ran, float it and let the board pull-down decide; if shutdown came in boot, drive it high
      sup_out_q <= !fw_shdn_d;
      sup_oe_q <= !fw_shdn_d;
    end else begin
      sup_out_q <= 1'b0;
      sup_oe_q <= 1'b1;
    end
  end
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      io_out_q <= '0;
      io_oe_q <= '0;
    end else if (state_d == DST_SHDN) begin
      io_out_q <= fw_shdn_d ? FW_DFLT_OUT_I : '0;
      io_oe_q <= fw_shdn_d ? FW_DFLT_OE_I : '0;
    end else if (state_d == DST_BOOT) begin
      io_out_q <= '0;
      io_oe_q <= '0;
    end else begin
      io_out_q <= IO_OUT_I;
      io_oe_q <= IO_OE_I;
    end
  end
  always_ff @(posedge REF_CLK_I or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      core_on_q <= 1'b1;
      radio_on_q <= 1'b0;
      ram_keep_q <= 1'b0;
    end else begin
      core_on_q <= (state_d != DST_SHDN);
      radio_on_q <= (state_d == DST_RUN) || (state_d == DST_LISTEN);
      ram_keep_q <= (state_d != DST_SHDN) && (state_d != DST_BOOT);
    end
  end
  assign LINK.supply_en_out = sup_out_q;
  assign LINK.supply_en_oe = sup_oe_q;
  assign LINK.io_out = io_out_q;
  assign LINK.io_oe = io_oe_q;
  assign CORE_SUPPLY_ON_O = core_on_q;
  assign RADIO_ON_O = radio_on_q;
  assign RAM_RETAIN_O = ram_keep_q;
  assign STATE_O = state_q;
endmodule // rspc_dev

/* File: core/rspc_host.sv */
`timescale 1ns/1ps
module rspc_host
  import rspc_pkg::*;
#(
  parameter int RESET_CYC_P = RESET_CYC,
  parameter int FW_DELAY_CYC_P = FW_LOAD_DELAY_CYC,
  parameter int SLOW_HALF_P = SLOW_HALF_CYC
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  rspc_if.host LINK,
  input wire logic SHUTDOWN_REQ_I,
  input wire logic RESET_REQ_I,
  input wire logic FW_LOADED_I,
  output logic FW_READY_O,
  output logic RESET_BUSY_O,
  output logic DEV_SUPPLY_EN_O,
  output logic [1:0] STATE_O
);
  if (RESET_CYC_P < 1 || FW_DELAY_CYC_P < 1 || SLOW_HALF_P < 1) begin : g_chk
    $error("host counts must be at least 1");
  end
  // counters are 24 bits wide; the reset and wait counters load the count minus one, the divider counts up to it
  if (RESET_CYC_P > 16777216 || FW_DELAY_CYC_P > 16777216 || SLOW_HALF_P > 16777216)
  begin : g_chk_w
    $error("host counts must fit 24-bit counters");
  end

  // =====================================================
  // slow reference clock divider
  // =====================================================
  logic [23:0] div_q;
  logic slow_q;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_q <= '0;
      slow_q <= 1'b0;
    end else if (div_q == 24'(SLOW_HALF_P - 1)) begin
      div_q <= '0;
      slow_q <= ~slow_q;
    end else begin
      div_q <= div_q + 24'h00_0001;
    end
  end

  // =====================================================
  // reset pulse, shutdown level, reload sequence
  // =====================================================
  rspc_host_state_t state_q;
  logic [23:0] cnt_q;
  logic [23:0] rst_cnt_q;
  logic rst_q;
  logic shdn_n_q;
  logic start_q;
  logic sup_q;

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (RESET_REQ_I && !rst_q) begin
      rst_q <= 1'b1;
      rst_cnt_q <= 24'(RESET_CYC_P - 1);
    end else if (rst_q) begin
      if (rst_cnt_q == '0) begin
        rst_q <= 1'b0;
      end else begin
        rst_cnt_q <= rst_cnt_q - 24'h00_0001;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      shdn_n_q <= 1'b0;
    end else begin
      shdn_n_q <= !SHUTDOWN_REQ_I;
    end
  end

  // any shutdown or reset loses the firmware, so wait and reload
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q <= HST_SHDN;
      cnt_q <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (!shdn_n_q || rst_q) begin
        state_q <= HST_SHDN;
      end else begin
        case (state_q)
          HST_SHDN: begin
            state_q <= HST_WAIT;
            cnt_q <= 24'(FW_DELAY_CYC_P - 1);
          end
          HST_WAIT: begin
            if (cnt_q == '0) begin
              state_q <= HST_LOAD;
            end else begin
              cnt_q <= cnt_q - 24'h00_0001;
            end
          end
          HST_LOAD: begin
            if (FW_LOADED_I) begin
              state_q <= HST_RUN;
              start_q <= 1'b1;
            end
          end
          default: begin
            state_q <= HST_RUN;
          end
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sup_q <= 1'b0;
    end else begin
      sup_q <= LINK.supply_en;
    end
  end

  assign LINK.reset_out = 1'b0;
  assign LINK.reset_oe = rst_q;
  assign LINK.shutdown_n = shdn_n_q;
  assign LINK.slow_clk = slow_q;
  assign LINK.test_out = 1'b0;
  assign LINK.test_oe = 1'b1;
  assign LINK.fw_start = start_q;
  assign FW_READY_O = (state_q == HST_LOAD);
  assign RESET_BUSY_O = rst_q;
  assign DEV_SUPPLY_EN_O = sup_q;
  assign STATE_O = state_q;
endmodule // rspc_host

/* File: sim/rspc_chk.sv */
`timescale 1ns/1ps
module rspc_chk #(
  parameter int NIO = 4
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic reset_n,
  input wire logic reset_oe,
  input wire logic shutdown_n,
  input wire logic fw_start,
  input wire logic test_en,
  input wire logic supply_en_out,
  input wire logic supply_en_oe,
  input wire logic [NIO-1:0] io_oe
);
  // =====================================================
  // helper state
  // =====================================================
  logic fw_seen_q;
  logic [3:0] sd_cnt_q;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fw_seen_q <= 1'h0;
    end else if (!reset_n) begin
      fw_seen_q <= 1'h0;
    end else if (fw_start) begin
      fw_seen_q <= 1'h1;
    end
  end
  // saturates so long shutdowns never wrap
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sd_cnt_q <= 4'h0;
    end else if (shutdown_n) begin
      sd_cnt_q <= 4'h0;
    end else if (sd_cnt_q != 4'hf) begin
      sd_cnt_q <= sd_cnt_q + 4'h1;
    end
  end
  // =====================================================
  // properties
  // =====================================================
  default clocking cb @(posedge REF_CLK_I); endclocking
  property p_rst_hold;
    disable iff (!RESET_N_I) !reset_n |=> supply_en_out && supply_en_oe && io_oe == '0;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("outputs left reset values during pin reset");
  property p_release;
    disable iff (!RESET_N_I) $rose(reset_n) |-> (supply_en_out && supply_en_oe)[*3];
  endproperty
  a_release: assert property (p_release)
    else $error("supply enable dropped right after reset release");
  property p_prefw;
    disable iff (!RESET_N_I || !reset_n)
      !fw_seen_q |-> supply_en_out && supply_en_oe && io_oe == '0;
  endproperty
  a_prefw: assert property (p_prefw)
    else $error("pin state wrong before firmware start");
  property p_fw_take;
    disable iff (!RESET_N_I || !reset_n) fw_start && !fw_seen_q |=> !supply_en_out && supply_en_oe;
  endproperty
  a_fw_take: assert property (p_fw_take)
    else $error("supply enable not driven low after firmware start");
  property p_run_hold;
    disable iff (!RESET_N_I || !reset_n)
      !supply_en_out && supply_en_oe && shutdown_n |=> !supply_en_out && supply_en_oe;
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("supply enable left low state while running");
  property p_sd_fw;
    disable iff (!RESET_N_I || !reset_n) sd_cnt_q >= 4'h4 && fw_seen_q |-> !supply_en_oe;
  endproperty
  a_sd_fw: assert property (p_sd_fw)
    else $error("supply enable still driven in shutdown after firmware");
  property p_leave;
    disable iff (!RESET_N_I || !reset_n)
      $rose(shutdown_n) |-> ##4 (supply_en_out && supply_en_oe && io_oe == '0);
  endproperty
  a_leave: assert property (p_leave)
    else $error("pins not in power-up state after leaving shutdown");
  property p_fw_pulse;
    disable iff (!RESET_N_I) fw_start |-> shutdown_n ##1 !fw_start;
  endproperty
  a_fw_pulse: assert property (p_fw_pulse)
    else $error("firmware start pulse malformed");
  property p_test;
    disable iff (!RESET_N_I) !test_en;
  endproperty
  a_test: assert property (p_test)
    else $error("test select seen high");
  // pulse is RESET_CYC_P cycles, 10 with the bench value
  property p_host_pulse;
    disable iff (!RESET_N_I)
      $rose(reset_oe) |-> reset_oe[*8] ##1 reset_oe[*2] ##1 !reset_oe;
  endproperty
  a_host_pulse: assert property (p_host_pulse)
    else $error("host reset pulse length wrong");
  c_fw: cover property (fw_start);
  c_sd_fw: cover property (sd_cnt_q == 4'h4 && fw_seen_q);
  c_pulse: cover property ($rose(reset_oe));
endmodule // rspc_chk

/* File: sim/rspc_tb.sv */
`timescale 1ns/1ps
module rspc_tb;
  import rspc_pkg::*;
  localparam int NIO_T = NUM_IO;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic sd_req = 1'h1;
  logic rst_req = 1'h0;
  logic fw_loaded = 1'h0;
  logic ps_en = 1'h0;
  logic [NIO_T-1:0] fn_out = '0;
  logic [NIO_T-1:0] fn_oe = '0;
  logic [NIO_T-1:0] df_out = '0;
  logic [NIO_T-1:0] df_oe = '0;
  logic sys_rst_n, core_on, radio_on, ram_on, test_mode, fw_ready, rst_busy, dev_sup;
  logic [2:0] dev_state;
  logic [1:0] host_state;
  logic [RTC_W-1:0] rtc;
  logic [CAL_W-1:0] cal;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h0000_254e;
  int it;
  always #12.5 clk = ~clk;
  // =====================================================
  // instances
  // =====================================================
  rspc_if #(.NIO(NIO_T)) u_rspc_if ();
  rspc_host #(.RESET_CYC_P(10), .FW_DELAY_CYC_P(20), .SLOW_HALF_P(4)) u_rspc_host (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .LINK(u_rspc_if), .SHUTDOWN_REQ_I(sd_req),
    .RESET_REQ_I(rst_req), .FW_LOADED_I(fw_loaded), .FW_READY_O(fw_ready),
    .RESET_BUSY_O(rst_busy), .DEV_SUPPLY_EN_O(dev_sup), .STATE_O(host_state));
  rspc_dev #(.NIO(NIO_T), .LISTEN_TICKS_P(4), .WINDOW_TICKS_P(2)) u_rspc_dev (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .LINK(u_rspc_if), .PS_EN_I(ps_en),
    .IO_OUT_I(fn_out), .IO_OE_I(fn_oe), .FW_DFLT_OUT_I(df_out), .FW_DFLT_OE_I(df_oe),
    .SYS_RESET_N_O(sys_rst_n), .CORE_SUPPLY_ON_O(core_on), .RADIO_ON_O(radio_on),
    .RAM_RETAIN_O(ram_on), .TEST_MODE_O(test_mode), .STATE_O(dev_state), .RTC_O(rtc),
    .CAL_PERIOD_O(cal));
  rspc_chk #(.NIO(NIO_T)) u_rspc_chk (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .reset_n(u_rspc_if.reset_n),
    .reset_oe(u_rspc_if.reset_oe), .shutdown_n(u_rspc_if.shutdown_n),
    .fw_start(u_rspc_if.fw_start), .test_en(u_rspc_if.test_en),
    .supply_en_out(u_rspc_if.supply_en_out), .supply_en_oe(u_rspc_if.supply_en_oe),
    .io_oe(u_rspc_if.io_oe));
  // =====================================================
  // tasks
  // =====================================================
  function automatic logic [NIO_T-1:0] driven(input logic [NIO_T-1:0] oe,
                                               input logic [NIO_T-1:0] v);
    return oe & v;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 400 && dev_state !== s; i++) step(1);
    check_val(dev_state, s);
  endtask
  task automatic boot();
    fn_out = NIO_T'($random(seed));
    fn_oe = NIO_T'($random(seed));
    sd_req = 1'h0;
    for (int i = 0; i < 400 && fw_ready !== 1'h1; i++) step(1);
    check_val(fw_ready, 1'h1);
    fw_loaded = 1'h1;
    step(1);
    fw_loaded = 1'h0;
    wait_state(3'h1);
    check_val(u_rspc_if.supply_en, 1'h0);
    check_val(ram_on & radio_on, 1'h1);
    check_val(u_rspc_if.shutdown_n, 1'h1);
    check_val(host_state, 2'h3);
    check_val(u_rspc_if.io_oe, fn_oe);
    check_val(driven(u_rspc_if.io_oe, u_rspc_if.io_out), driven(fn_oe, fn_out));
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // =====================================================
  // sequence
  // =====================================================
  initial begin
    step(5);
    check_val(sys_rst_n, 1'h0);
    step(5);
    rst_n = 1'h1;
    step(8);
    check_val(sys_rst_n, 1'h1);
    check_val(dev_state, 3'h4);
    check_val(u_rspc_if.supply_en, 1'h1);
    check_val(u_rspc_if.io_oe, '0);
    check_val(test_mode, 1'h0);
    check_val(dev_sup, 1'h1);
    $display("test power_up done");
    for (it = 0; it < 3; it++) begin
      boot();
      df_out = NIO_T'($random(seed));
      df_oe = NIO_T'($random(seed));
      if (it == 0) df_oe = '1;
      sd_req = 1'h1;
      step(6);
      check_val(dev_state, 3'h4);
      check_val(core_on, 1'h0);
      check_val(u_rspc_if.io_oe, df_oe);
      check_val(driven(u_rspc_if.io_oe, u_rspc_if.io_out), driven(df_oe, df_out));
      check_val(u_rspc_if.supply_en, 1'h0);
      check_val(dev_sup, 1'h0);
      check_val({radio_on, ram_on}, 2'h0);
      sd_req = 1'h0;
      step(6);
      check_val(dev_state, 3'h0);
      check_val(u_rspc_if.io_oe, '0);
      check_val(u_rspc_if.supply_en, 1'h1);
      check_val(core_on, 1'h1);
      $display("test shutdown cycle %0d done", it);
    end
    boot();
    ps_en = 1'h1;
    step(2);
    check_val(dev_state, 3'h2);
    check_val({radio_on, ram_on}, 2'h1);
    wait_state(3'h3);
    check_val(radio_on, 1'h1);
    wait_state(3'h2);
    check_val(cal, 16'h0008);
    check_val(rtc != '0, 1'h1);
    ps_en = 1'h0;
    step(2);
    check_val(dev_state, 3'h1);
    ps_en = 1'h1;
    wait_state(3'h3);
    ps_en = 1'h0;
    step(2);
    check_val(dev_state, 3'h1);
    $display("test power_save done");
    rst_req = 1'h1;
    step(1);
    rst_req = 1'h0;
    step(3);
    check_val(rst_busy, 1'h1);
    check_val(sys_rst_n, 1'h0);
    check_val(u_rspc_if.io_oe, '0);
    check_val(u_rspc_if.supply_en, 1'h1);
    check_val(host_state, 2'h0);
    boot();
    $display("test pin_reset done");
    print_verdict();
  end
  // whole run needs a few hundred cycles; 20000 leaves wide margin
  initial begin
    #500000;
    miscompares++;
    print_verdict();
  end
endmodule // rspc_tb
